// ==== rtl/virtual_address_relocation.sv ====
// Notes on behaviour
// RL1 - Top three address bits pick one of eight pages in a set.
// RL2 - Address is offset plus base shifted left six.
// RL3 - Address is 18 bits; carry past bit 17 dropped.
// RL4 - Console start clears status zero; continue does not.
// RL5 - Console stepping never carries bit 15 into 16.
// RL6 - Display: relocated, console-loaded or virtual address.
// RL7 - Identity bases are n*0200 octal; I/O page 07600.
// RL8 - Move-previous: stack in current mode, operand previous.
// RL9 - User-to-user move-from-I reads via user data set.
// RL10 - Vectors are fetched in kernel space.
// RL11 - Returns pop counter and status from stack.
// RL12 - Keys 1, 4, 5 trap at instruction end if enabled.
// RL13 - Trapping keys set accessed flag even if disabled.
// RL14 - All matching descriptors flagged; status loaded once.
// RL15 - Descriptor write clears accessed and written flags.
// RL16 - Key 2 reads freely, key 5 traps writes, 6 never.
// RL17 - Key 2 aborts writes, permits reads.
// RL18 - Status zero bit 0 enables relocation.
// RL19 - Bit 9 clear: no trap, flags still logged.
// RL20 - Trap vectors through kernel data 250.
// RL21 - Keys 0, 3, 7 set nonresident flag and abort.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module virtual_address_relocation
    import mmu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] processor_status_word,
    input wire logic req_valid,
    output logic req_ready,
    input wire core_req_type req,
    output logic resp_valid,
    output core_resp_type resp,
    input wire logic instr_end,
    output logic stat_trap,
    output logic [15:0] stat_trap_vector,
    input wire console_type console,
    output logic [17:0] display_address
);
    typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_RESP} rd_state_type;

    typedef struct packed {
        logic [15:0] sr0;
        logic [2:0] sr3;
        logic busy;
        core_req_type pend;
        logic [5:0] pend_idx;
        logic resp_valid;
        core_resp_type resp;
        logic trap_pend;
        logic status_loaded;
        logic stat_trap;
        logic [17:0] cons_addr;
        logic [17:0] last_pa;
        logic [15:0] last_va;
        logic [17:0] disp;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [15:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        rd_state_type rstate;
        logic [11:0] raddr;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    state_type cur_ff;
    state_type nxt_ff;

    logic [15:0] a_base;
    logic [15:0] a_desc;
    logic [15:0] b_base;
    logic [15:0] b_desc;
    logic we_base;
    logic we_desc;
    logic [5:0] w_idx;
    logic [15:0] w_data;
    logic [5:0] a_idx;
    logic [1:0] cur_mode;
    logic [1:0] prev_mode;
    logic [1:0] sel_mode;
    logic sel_dspace;
    logic [2:0] key;
    logic relocate;
    logic nonres;
    logic ro_abort;
    logic trap_cond;
    logic frozen;
    logic [17:0] reloc_pa;
    logic hw_desc_write;
    logic bus_wr_go;
    logic bus_wr_table;
    logic [15:0] desc_flagged;

    page_table_ram u_table (
        .aclk(aclk),
        .a_idx(a_idx),
        .a_base(a_base),
        .a_desc(a_desc),
        .b_idx(s_axi_araddr[7:2]),
        .b_base(b_base),
        .b_desc(b_desc),
        .we_base(we_base),
        .we_desc(we_desc),
        .w_idx(w_idx),
        .w_data(w_data)
    );

    // D-space enable of a mode
    function automatic logic split_on(input logic [1:0] m,
                                      input logic [2:0] sr3);
        logic r;
        r = 1'b0;
        if (m == MODE_USER) begin
            r = sr3[SR3_USER_D];
        end else if (m == MODE_SUPER) begin
            r = sr3[SR3_SUPER_D];
        end else if (m == MODE_KERNEL) begin
            r = sr3[SR3_KERNEL_D];
        end
        return r;
    endfunction

    // Register set selection at request time, using live status word
    always_comb begin
        cur_mode = processor_status_word[PSW_CUR_LSB +: 2];
        prev_mode = processor_status_word[PSW_PREV_LSB +: 2];
        sel_mode = cur_mode;
        sel_dspace = req.dspace && split_on(cur_mode, cur_ff.sr3);
        if (req.vector_fetch) begin
            sel_mode = MODE_KERNEL; // see RL10
            sel_dspace = split_on(MODE_KERNEL, cur_ff.sr3); // see RL20
        end else if (req.stack_pop || req.stack_implied) begin
            sel_mode = cur_mode; // see RL11 see RL8
        end else if (req.use_prev) begin
            sel_mode = prev_mode; // see RL8
            sel_dspace = req.dspace && split_on(prev_mode, cur_ff.sr3);
            if (req.ispace_move && cur_mode == MODE_USER
                    && prev_mode == MODE_USER
                    && cur_ff.sr3[SR3_USER_D]) begin
                sel_dspace = 1'b1; // see RL9
            end
        end
        a_idx = {sel_mode, sel_dspace, req.virtual_address[15:13]}; // see RL1
    end

    // Relocation and protection checks on the looked-up entry
    always_comb begin
        key = a_desc[DESC_KEY_LSB +: 3];
        relocate = cur_ff.busy && cur_ff.sr0[SR0_ENABLE]; // see RL18
        nonres = relocate && (key == 3'h0 || key == 3'h3
                              || key == 3'h7); // see RL21
        ro_abort = relocate && cur_ff.pend.write
                   && (key == KEY_RO_TRAP || key == KEY_RO); // see RL17
        // Key 6 falls through both terms, so it never traps
        trap_cond = relocate && ((!cur_ff.pend.write
                    && (key == KEY_RO_TRAP || key == KEY_RW_TRAP))
                    || (cur_ff.pend.write && (key == KEY_RW_TRAP
                    || key == KEY_RW_TRAP_W))); // see RL16
        frozen = |cur_ff.sr0[SR0_NONRES:SR0_RDONLY];
        // Sum truncated to 18 bits so addresses wrap
        reloc_pa = PA_W'({a_base, 6'h00})
                   + PA_W'(cur_ff.pend.virtual_address[PAGE_OFS_W-1:0]);
        // see RL2 see RL3
        desc_flagged = a_desc;
        if (trap_cond) begin
            desc_flagged[DESC_A] = 1'b1; // see RL13 see RL14
        end
        if (cur_ff.pend.write && !nonres && !ro_abort) begin
            desc_flagged[DESC_W] = 1'b1;
        end
        hw_desc_write = relocate && desc_flagged != a_desc;
    end

    // Table write port: hardware flag logging beats the bus
    always_comb begin
        bus_wr_go = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid
                    && !hw_desc_write;
        bus_wr_table = cur_ff.aw_addr[11:9] == 3'h0;
        we_base = 1'b0;
        we_desc = 1'b0;
        w_idx = cur_ff.pend_idx;
        w_data = desc_flagged;
        if (hw_desc_write) begin
            we_desc = 1'b1;
        end else if (bus_wr_go && bus_wr_table) begin
            w_idx = cur_ff.aw_addr[7:2];
            w_data = cur_ff.wdata;
            if (cur_ff.aw_addr[8]) begin
                we_desc = 1'b1;
                w_data[DESC_A] = 1'b0; // see RL15
                w_data[DESC_W] = 1'b0; // see RL15
            end else begin
                we_base = 1'b1;
            end
        end
    end

    // Next state of the whole block
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.resp_valid = 1'b0;
        nxt_ff.stat_trap = 1'b0;

        // Core request taken when idle, answered two edges later
        if (req_valid && !cur_ff.busy) begin
            nxt_ff.busy = 1'b1;
            nxt_ff.pend = req;
            nxt_ff.pend_idx = a_idx;
        end
        if (cur_ff.busy) begin
            nxt_ff.busy = 1'b0;
            nxt_ff.resp_valid = 1'b1;
            nxt_ff.resp.abort_nonres = nonres;
            nxt_ff.resp.abort_readonly = ro_abort;
            nxt_ff.resp.physical_address = relocate ? reloc_pa
                : {2'b00, cur_ff.pend.virtual_address};
            nxt_ff.last_pa = nxt_ff.resp.physical_address;
            nxt_ff.last_va = cur_ff.pend.virtual_address;
        end

        // Bus register write; hardware flag sets applied after it
        if (bus_wr_go) begin
            nxt_ff.aw_got = 1'b0;
            nxt_ff.w_got = 1'b0;
            nxt_ff.bvalid = 1'b1;
            nxt_ff.bresp = RESP_OKAY;
            if (cur_ff.aw_addr == SR0_OFF) begin
                nxt_ff.sr0 = cur_ff.wdata;
            end else if (cur_ff.aw_addr == SR3_OFF) begin
                nxt_ff.sr3 = cur_ff.wdata[2:0];
            end else if (!bus_wr_table) begin
                nxt_ff.bresp = RESP_SLVERR;
            end
        end
        if (s_axi_awvalid && !cur_ff.aw_got) begin
            nxt_ff.aw_got = 1'b1;
            nxt_ff.aw_addr = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && !cur_ff.w_got) begin
            nxt_ff.w_got = 1'b1;
            nxt_ff.wdata = s_axi_wdata[15:0];
        end
        if (cur_ff.bvalid && s_axi_bready) begin
            nxt_ff.bvalid = 1'b0;
        end

        // Abort and trap flags; page info frozen while an abort stands
        if (nonres || ro_abort) begin
            if (!frozen) begin
                nxt_ff.sr0[SR0_MODE_LSB +: 2] = cur_ff.pend_idx[5:4];
                nxt_ff.sr0[SR0_SPACE] = cur_ff.pend_idx[3];
                nxt_ff.sr0[SR0_PAGE_LSB +: 3] = cur_ff.pend_idx[2:0];
            end
            nxt_ff.sr0[SR0_NONRES] = nxt_ff.sr0[SR0_NONRES] | nonres;
            nxt_ff.sr0[SR0_RDONLY] = nxt_ff.sr0[SR0_RDONLY] | ro_abort;
        end else if (trap_cond) begin
            nxt_ff.trap_pend = 1'b1; // see RL12
            if (cur_ff.sr0[SR0_TRAP_EN] && !cur_ff.status_loaded
                    && !frozen) begin
                nxt_ff.status_loaded = 1'b1; // see RL14
                nxt_ff.sr0[SR0_TRAP] = 1'b1; // see RL19
                nxt_ff.sr0[SR0_MODE_LSB +: 2] = cur_ff.pend_idx[5:4];
                nxt_ff.sr0[SR0_SPACE] = cur_ff.pend_idx[3];
                nxt_ff.sr0[SR0_PAGE_LSB +: 3] = cur_ff.pend_idx[2:0];
            end
        end

        // Trap only at instruction end and only while enabled
        if (instr_end) begin
            nxt_ff.stat_trap = cur_ff.trap_pend
                               && cur_ff.sr0[SR0_TRAP_EN]; // see RL12 see RL19
            // A trap seen in this very cycle must not be lost
            nxt_ff.trap_pend = trap_cond && !nonres && !ro_abort;
            nxt_ff.status_loaded = 1'b0;
        end

        // Console start drops relocation; continue touches nothing
        if (console.start) begin
            nxt_ff.sr0 = SR0_RESET; // see RL4
        end
        if (console.load_addr) begin
            nxt_ff.cons_addr = console.switches;
        end else if (console.step) begin
            nxt_ff.cons_addr[15:0] = cur_ff.cons_addr[15:0]
                                     + CONS_STEP; // see RL5
        end
        unique case (console.sel)
            DISP_PROGRAM_PHYSICAL_DISPLAY: nxt_ff.disp = cur_ff.last_pa; // see RL6
            DISP_CONSOLE_PHYSICAL_DISPLAY: nxt_ff.disp = cur_ff.cons_addr; // see RL6
            DISP_VIRTUAL: nxt_ff.disp = {2'b00, cur_ff.last_va}; // see RL6
            default: nxt_ff.disp = cur_ff.last_pa;
        endcase

        // Read channel: fixed two-cycle lookup then hold until rready
        unique case (cur_ff.rstate)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_ff.raddr = {s_axi_araddr[11:2], 2'b00};
                    nxt_ff.rstate = RD_MEM;
                end
            end
            RD_MEM: begin
                nxt_ff.rresp = RESP_OKAY;
                nxt_ff.rdata = 32'h0000_0000;
                if (cur_ff.raddr[11:9] == 3'h0) begin
                    nxt_ff.rdata[15:0] = cur_ff.raddr[8] ? b_desc : b_base;
                end else if (cur_ff.raddr == SR0_OFF) begin
                    nxt_ff.rdata[15:0] = cur_ff.sr0;
                end else if (cur_ff.raddr == SR3_OFF) begin
                    nxt_ff.rdata[2:0] = cur_ff.sr3;
                end else begin
                    nxt_ff.rresp = RESP_SLVERR;
                end
                nxt_ff.rstate = RD_RESP;
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    nxt_ff.rstate = RD_IDLE;
                end
            end
        endcase
    end

    // Single register stage for all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_ff <= '0;
            cur_ff.sr0 <= SR0_RESET;
            cur_ff.sr3 <= SR3_RESET;
            cur_ff.rstate <= RD_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Handshakes are combinational, data from flip-flops
    assign req_ready = !cur_ff.busy;
    assign resp_valid = cur_ff.resp_valid;
    assign resp = cur_ff.resp;
    assign stat_trap = cur_ff.stat_trap;
    assign stat_trap_vector = STAT_TRAP_VECTOR; // see RL20
    assign display_address = cur_ff.disp;
    assign s_axi_awready = !cur_ff.aw_got;
    assign s_axi_wready = !cur_ff.w_got;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_arready = cur_ff.rstate == RD_IDLE;
    assign s_axi_rvalid = cur_ff.rstate == RD_RESP;
    assign s_axi_rdata = cur_ff.rdata;
    assign s_axi_rresp = cur_ff.rresp;
endmodule // virtual_address_relocation

// ==== rtl/mmu_pkg.sv ====
package mmu_pkg;

    // Address widths and relocation shift
    localparam int VA_W = 16;
    localparam int PA_W = 18;
    localparam int PAGE_OFS_W = 13;
    localparam int BASE_SHIFT = 6;
    localparam logic [15:0] CONS_STEP = 16'h0002;

    // Bus register map (byte addresses)
    localparam logic [11:0] BASE_REG_OFF = 12'h000;
    localparam logic [11:0] DESC_REG_OFF = 12'h100;
    localparam logic [11:0] SR0_OFF = 12'h200;
    localparam logic [11:0] SR3_OFF = 12'h204;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // mmu_status_zero fields
    localparam int SR0_ENABLE = 0;
    localparam int SR0_PAGE_LSB = 1;
    localparam int SR0_SPACE = 4;
    localparam int SR0_MODE_LSB = 5;
    localparam int SR0_MAINT = 8;
    localparam int SR0_TRAP_EN = 9;
    localparam int SR0_TRAP = 12;
    localparam int SR0_RDONLY = 13;
    localparam int SR0_NONRES = 15;
    localparam logic [15:0] SR0_RESET = 16'h0000;

    // space_split_control fields, one D-space enable per mode
    localparam int SR3_USER_D = 0;
    localparam int SR3_SUPER_D = 1;
    localparam int SR3_KERNEL_D = 2;
    localparam logic [2:0] SR3_RESET = 3'h0;

    // page_descriptor_register fields
    localparam int DESC_KEY_LSB = 0;
    localparam int DESC_W = 6;
    localparam int DESC_A = 7;

    // access_key_field codes
    localparam logic [2:0] KEY_RO_TRAP = 3'h1;
    localparam logic [2:0] KEY_RO = 3'h2;
    localparam logic [2:0] KEY_RW_TRAP = 3'h4;
    localparam logic [2:0] KEY_RW_TRAP_W = 3'h5;

    // Processor modes as held in the status word
    localparam logic [1:0] MODE_KERNEL = 2'b00;
    localparam logic [1:0] MODE_SUPER = 2'b01;
    localparam logic [1:0] MODE_USER = 2'b11;
    localparam int PSW_CUR_LSB = 14;
    localparam int PSW_PREV_LSB = 12;

    // Statistical trap vector, kernel D virtual 250 octal
    localparam logic [15:0] STAT_TRAP_VECTOR = 16'h00a8;

    typedef enum logic [1:0] {
        DISP_PROGRAM_PHYSICAL_DISPLAY,
        DISP_CONSOLE_PHYSICAL_DISPLAY,
        DISP_VIRTUAL
    } disp_sel_type;

    // One virtual memory reference from the core
    typedef struct packed {
        logic [15:0] virtual_address;
        logic write;
        logic dspace;
        logic use_prev;
        logic stack_implied;
        logic ispace_move;
        logic vector_fetch;
        logic stack_pop;
    } core_req_type;

    typedef struct packed {
        logic [17:0] physical_address;
        logic abort_nonres;
        logic abort_readonly;
    } core_resp_type;

    typedef struct packed {
        logic start;
        logic cont;
        logic load_addr;
        logic step;
        logic [17:0] switches;
        disp_sel_type sel;
    } console_type;

endpackage

// ==== rtl/page_table_ram.sv ====
`timescale 1ns/1ps
module page_table_ram
    import mmu_pkg::*;
(
    input wire logic aclk,
    input wire logic [5:0] a_idx,
    output logic [15:0] a_base,
    output logic [15:0] a_desc,
    input wire logic [5:0] b_idx,
    output logic [15:0] b_base,
    output logic [15:0] b_desc,
    input wire logic we_base,
    input wire logic we_desc,
    input wire logic [5:0] w_idx,
    input wire logic [15:0] w_data
);
    logic [15:0] base_mem [0:63];
    logic [15:0] desc_mem [0:63];

    // Two registered read ports, one write port per table
    always_ff @(posedge aclk) begin
        if (we_base) begin
            base_mem[w_idx] <= w_data;
        end
        if (we_desc) begin
            desc_mem[w_idx] <= w_data;
        end
        a_base <= base_mem[a_idx];
        a_desc <= desc_mem[a_idx];
        b_base <= base_mem[b_idx];
        b_desc <= desc_mem[b_idx];
    end
endmodule // page_table_ram

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
module core_model
    import mmu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire core_req_type cmd,
    input wire logic req_ready,
    output logic req_valid,
    output core_req_type req
);
    // Payload inverted after release so stale data cannot pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_valid <= 1'b0;
            req <= '0;
        end else if (go) begin
            req_valid <= 1'b1;
            req <= cmd;
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req <= ~req;
        end
    end
endmodule // core_model

// ==== bench/virtual_address_relocation_properties.sv ====
`timescale 1ns/1ps
module reloc_checker
    import mmu_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic instr_end,
    input wire logic stat_trap,
    input wire logic [15:0] stat_trap_vector,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire console_type console,
    input wire logic [17:0] display_address
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Core handshake steps and console address load
    sequence taken_s;
        req_valid && req_ready;
    endsequence
    sequence answer_s;
        !req_ready && !resp_valid ##1 resp_valid;
    endsequence
    sequence cons_load_s;
        console.load_addr && console.sel == DISP_CONSOLE_PHYSICAL_DISPLAY ##1
        !console.load_addr && !console.step && console.sel == DISP_CONSOLE_PHYSICAL_DISPLAY;
    endsequence
    resp_timing_a: assert property (
        taken_s |=> answer_s) else $error("core answer out of time");
    resp_pulse_a: assert property (
        resp_valid |=> !resp_valid) else $error("answer strobe too long");
    trap_pulse_a: assert property (
        stat_trap |=> !stat_trap) else $error("trap strobe too long");
    trap_cause_a: assert property (
        stat_trap |-> $past(instr_end)) else $error("trap not at end");
    trap_vector_a: assert property (
        stat_trap_vector == 16'h00a8) else $error("wrong trap vector");
    read_timing_a: assert property (
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer out of time");
    cons_load_a: assert property (
        cons_load_s |=> display_address == $past(console.switches, 2))
        else $error("loaded address not shown");
    cons_step_a: assert property (
        (console.sel == DISP_CONSOLE_PHYSICAL_DISPLAY && !console.load_addr) [*3]
        |=> $stable(display_address[17:16])) else $error("step carried");
endmodule // reloc_checker

bind virtual_address_relocation reloc_checker chk (
    .aclk, .aresetn, .req_valid, .req_ready, .resp_valid, .instr_end,
    .stat_trap, .stat_trap_vector, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .console, .display_address
);

// ==== bench/virtual_address_relocation_tb.sv ====
`timescale 1ns/1ps
module virtual_address_relocation_tb
    import mmu_pkg::*;
;
    typedef struct packed {
        logic [3:0] m;
        logic [15:0] va;
        logic [6:0] fl;
        logic [17:0] pa;
        logic [1:0] ab;
    } row_type;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid, req_valid, req_ready, resp_valid, stat_trap;
    logic [15:0] processor_status_word = 16'h0;
    logic go = 1'b0, instr_end = 1'b0;
    core_req_type req, cmd = '0;
    core_resp_type resp;
    logic [15:0] stat_trap_vector;
    console_type console = '{1'b0, 1'b0, 1'b0, 1'b0, 18'h3fffe,
                             DISP_PROGRAM_PHYSICAL_DISPLAY};
    logic [17:0] display_address;
    int miscompares = 0, num_checks = 0, cycles = 0;
    // Kernel I bases (identity, wrap, I/O page) and keys
    logic [15:0] kb [8] = '{16'h0000, 16'h0080, 16'h0100, 16'h0180,
                            16'h0200, 16'hffff, 16'h0300, 16'h0f80};
    logic [2:0] kk [8] = '{3'h6, 3'h2, 3'h0, 3'h7, 3'h5, 3'h6, 3'h3, 3'h6};
    // {address, data}: user pages, split, status
    logic [27:0] uc [8] = '{28'h0c00200, 28'h1c00001, 28'h0c40100,
        28'h1c40004, 28'h0e00100, 28'h1e00006, 28'h2040001, 28'h2000001};
    // Mode, address, request flags, expected address and aborts
    row_type rows [14] = '{
        '{4'h0, 16'h0010, 7'h00, 18'h00010, 2'h0},
        '{4'h0, 16'h2020, 7'h00, 18'h02020, 2'h0},
        '{4'h0, 16'h2020, 7'h40, 18'h0, 2'h1},
        '{4'h0, 16'h4000, 7'h00, 18'h0, 2'h2},
        '{4'h0, 16'h6000, 7'h00, 18'h0, 2'h2},
        '{4'h0, 16'hc000, 7'h40, 18'h0, 2'h2},
        '{4'h0, 16'hf004, 7'h00, 18'h3f004, 2'h0},
        '{4'h0, 16'ha100, 7'h00, 18'h000c0, 2'h0},
        '{4'h0, 16'h8000, 7'h40, 18'h08000, 2'h0},
        '{4'h3, 16'h0010, 7'h10, 18'h08010, 2'h0},
        '{4'h3, 16'h0010, 7'h18, 18'h00010, 2'h0},
        '{4'hf, 16'h0010, 7'h02, 18'h00010, 2'h0},
        '{4'hf, 16'h0010, 7'h01, 18'h08010, 2'h0},
        '{4'hf, 16'h0010, 7'h14, 18'h04010, 2'h0}
    };
    virtual_address_relocation uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .processor_status_word, .req_valid,
        .req_ready, .req, .resp_valid, .resp, .instr_end, .stat_trap,
        .stat_trap_vector, .console, .display_address
    );
    core_model core (
        .aclk, .aresetn, .go, .cmd, .req_ready, .req_valid, .req
    );
    initial begin
        forever #50 aclk = ~aclk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard well above run length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("ERROR at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Handshakes sampled at rising edges
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(d, e);
    endtask
    // One core reference
    task automatic acc(input logic [3:0] m, input logic [15:0] va,
                       input logic [6:0] f);
        @(posedge aclk);
        processor_status_word <= {m, 12'h0};
        cmd <= {va, f};
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(negedge aclk); while (resp_valid !== 1'b1);
    endtask
    task automatic end_instr(input logic [31:0] e);
        @(posedge aclk);
        instr_end <= 1'b1;
        @(posedge aclk);
        instr_end <= 1'b0;
        @(negedge aclk);
        check(32'(stat_trap), e);
    endtask
    // Control order: start, continue, load, step
    task automatic con_op(input logic [3:0] c, input disp_sel_type s,
                          input logic [17:0] e);
        @(posedge aclk);
        console.sel <= s;
        {console.start, console.cont, console.load_addr, console.step} <= c;
        @(posedge aclk);
        {console.start, console.cont, console.load_addr, console.step} <= 0;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check(32'(display_address), 32'(e));
    endtask
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(32'(req_ready), 32'h1);
        rd_chk(SR0_OFF, 32'h0);
        rd_chk(SR3_OFF, 32'h0);
        acc(4'h0, 16'hf004, 7'h40);
        check(32'(resp), 32'h3c010);
        $display("reset test done");
        for (int p = 0; p < 8; p++) begin
            axi_wr(BASE_REG_OFF + 12'(4 * p), {16'h0, kb[p]});
            axi_wr(DESC_REG_OFF + 12'(4 * p), {29'h0, kk[p]});
        end
        foreach (uc[i]) axi_wr(uc[i][27:16], {16'h0, uc[i][15:0]});
        foreach (rows[i]) begin
            acc(rows[i].m, rows[i].va, rows[i].fl);
            if (rows[i].ab != 2'h0)
                check(32'(resp[1:0]), 32'(rows[i].ab));
            else
                check(32'(resp), 32'({rows[i].pa, 2'h0}));
        end
        $display("mapping rows done");
        rd_chk(12'h110, 32'h00c5);
        axi_wr(12'h110, 32'h0005);
        rd_chk(12'h110, 32'h0005);
        end_instr(32'h0);
        axi_wr(12'h1c0, 32'h0001);
        axi_wr(12'h1c4, 32'h0004);
        axi_wr(SR0_OFF, 32'h0201);
        acc(4'hf, 16'h0010, 7'h00);
        acc(4'hf, 16'h2010, 7'h00);
        end_instr(32'h1);
        check(32'(stat_trap_vector), 32'h00a8);
        rd_chk(SR0_OFF, 32'h1261);
        rd_chk(12'h1c0, 32'h0081);
        rd_chk(12'h1c4, 32'h0084);
        $display("statistics test done");
        con_op(4'h2, DISP_CONSOLE_PHYSICAL_DISPLAY, 18'h3fffe);
        con_op(4'h1, DISP_CONSOLE_PHYSICAL_DISPLAY, 18'h30000);
        con_op(4'h4, DISP_PROGRAM_PHYSICAL_DISPLAY, 18'h04010);
        rd_chk(SR0_OFF, 32'h1261);
        con_op(4'h8, DISP_VIRTUAL, 18'h02010);
        rd_chk(SR0_OFF, 32'h0);
        axi_rd(12'h300, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(RESP_SLVERR));
        $display("console test done");
        report_and_stop();
    end
endmodule // virtual_address_relocation_tb
